// File: pkg/fault_log_defines.vh
// Constants for the fault log record formatter
`ifndef FAULT_LOG_DEFINES_VH
`define FAULT_LOG_DEFINES_VH
`define LOG_LEN 8'h93
`define PAGE_BYTES 8'h14
`define PAGE_COUNT 3'h6
`define PAGE_BASE 8'h1B
`define LAST_STEP 5'h19
`define SRC_FORCED 8'hFF
`define TICK_NS 200000
`define CLK_NS 4
`define B_SRC 8'h00
`define B_TIME0 8'h01
`define B_VOUTPK 8'h07
`define B_IOUTPK 8'h0B
`define B_IINCPK 8'h0D
`define B_VINPK 8'h0F
`define B_TEXT 8'h11
`define B_TINT 8'h15
`define B_TEXTPK 8'h17
`define P_VOUT 8'h00
`define P_IOUT 8'h04
`define P_IINC 8'h06
`define P_VIN 8'h08
`define P_IIN 8'h0A
`define P_STVOUT 8'h0C
`define P_STWORD 8'h0E
`define P_STMFR 8'h12
`endif

// File: design/page_store.v
// One event page of captured ADC readings
`timescale 1ns/100ps
`default_nettype none
module page_store (
  input wire clk,
  input wire rst_n,
  input wire load,
  input wire [159:0] page_in,
  output reg [159:0] page_out
);
  // Holds one pass of readings until overwritten
  always @(posedge clk) begin
    if (!rst_n) begin
      page_out <= 160'h0;
    end else if (load) begin
      page_out <= page_in;
    end
  end
endmodule // page_store
`default_nettype wire

// File: design/fault_log_record_formatter.v
// Fault log record capture and byte serving
`timescale 1ns/100ps
`default_nettype none
`include "fault_log_defines.vh"
// Operation
// - Bytes 13-14 carry the channel input current peak, high byte first.
// - Bytes 15-16 carry the input voltage peak, high byte first.
// - Bytes 17-18 carry the external temperature of the last event, high byte first.
// - Bytes 21-22 carry the die temperature of the last event, high byte first.
// - Bytes 23-24 carry the external temperature peak, high byte first.
// - Each event page is one full multiplexer pass, the newest holding the fault pass.
// - A fault mid-sequence waits until step 25 completes before committing.
// - After that pass the header and all six pages are committed as one log.
// - The newest page starts at byte 27 with output voltage, currents, input voltage, status.
// - The block length is 147 with a log present and zero otherwise.
// - Byte 0 holds the trigger source code, 0xFF for a forced store.
// - Bytes 1-6 hold a 48-bit 200 us time counter, low byte first.
// - A log is triggered only while fault logging is enabled; a capture already waiting still commits at step 25 if it drops.
module fault_log_record_formatter #(
  parameter TICK_CYCLES = `TICK_NS / `CLK_NS
) (
  input wire clk,
  input wire rst_n,
  input wire logging_enable,
  input wire fault_event,
  input wire [7:0] fault_code,
  input wire forced_log_store,
  input wire log_clear,
  input wire step_done,
  input wire [4:0] adc_step,
  input wire [15:0] vout_peak,
  input wire [15:0] iout_peak,
  input wire [15:0] channel_input_current_peak,
  input wire [15:0] input_voltage_peak,
  input wire [15:0] external_temperature_peak,
  input wire [15:0] ext_temp,
  input wire [15:0] die_temp,
  input wire [15:0] vout,
  input wire [15:0] iout,
  input wire [15:0] channel_input_current,
  input wire [15:0] vin,
  input wire [15:0] iin,
  input wire [7:0] status_vout,
  input wire [15:0] status_word,
  input wire [7:0] status_mfr,
  input wire [7:0] rd_addr,
  output reg [7:0] rd_data,
  output reg [7:0] block_length,
  output reg log_present,
  output wire commit_pulse
);
  // Capture sequencer states
  localparam ST_IDLE = 2'b00;
  localparam ST_WAIT = 2'b01;
  localparam ST_DONE = 2'b10;
  // Sequencer, time base and header
  reg [1:0] state_r;
  reg [31:0] tick_r;
  reg [47:0] fault_time_counter_r;
  reg [47:0] time_snap_r;
  reg [7:0] src_r;
  reg [127:0] hdr_r;
  reg [2:0] head_r; // Slot the next pass fills
  reg commit_r;
  // Page ring
  reg [159:0] live_page;
  wire [159:0] pages [0:5];
  wire [5:0] page_load;
  wire pass_end;
  // Read path decode, all combinational
  reg [7:0] page_rel;
  reg [7:0] page_quot;
  reg [7:0] page_off;
  reg [2:0] page_idx;
  reg [2:0] slot;
  reg [159:0] sel_page;
  // Final step of the pass seen this cycle
  assign pass_end = step_done && (adc_step == `LAST_STEP);
  assign commit_pulse = commit_r;

  // Free-running 200 us time base
  always @(posedge clk) begin
    if (!rst_n) begin
      tick_r <= 32'h0;
      fault_time_counter_r <= 48'h0;
    end else if (tick_r == TICK_CYCLES - 1) begin
      tick_r <= 32'h0;
      fault_time_counter_r <= fault_time_counter_r + 48'h1;
    end else begin
      tick_r <= tick_r + 32'h1;
    end
  end

  // Page layout of the live pass, reserved bytes zero
  always @* begin
    live_page = 160'h0;
    live_page[159:144] = vout;
    live_page[127:112] = iout;
    live_page[111:96] = channel_input_current;
    live_page[95:80] = vin;
    live_page[79:64] = iin;
    live_page[63:56] = status_vout;
    live_page[47:32] = status_word;
    live_page[15:8] = status_mfr;
  end

  // Ring of six pages, one full pass per slot
  // A reset empties the ring, so page order restarts at slot zero
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_page
      assign page_load[g] = pass_end && (state_r != ST_DONE) && (head_r == g);
      page_store u_page (
        .clk(clk),
        .rst_n(rst_n),
        .load(page_load[g]),
        .page_in(live_page),
        .page_out(pages[g])
      );
    end
  endgenerate

  // Capture sequencer: trigger, wait for final step, commit
  always @(posedge clk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      head_r <= 3'h0;
      src_r <= 8'h0;
      hdr_r <= 128'h0;
      time_snap_r <= 48'h0;
      commit_r <= 1'b0;
      log_present <= 1'b0;
    end else begin
      commit_r <= 1'b0;
      // Head moves once per pass, frozen while a log is held
      if (pass_end && state_r != ST_DONE) begin
        head_r <= (head_r == `PAGE_COUNT - 3'h1) ? 3'h0 : head_r + 3'h1;
      end
      case (state_r)
        ST_IDLE: begin
          // A pass end in the trigger cycle is not the fault pass
          if (logging_enable && (fault_event || forced_log_store)) begin
            src_r <= forced_log_store ? `SRC_FORCED : fault_code;
            time_snap_r <= fault_time_counter_r;
            state_r <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (pass_end) begin
            // Header taken at commit, so temperatures are of the last event
            hdr_r <= {vout_peak, iout_peak, channel_input_current_peak, input_voltage_peak,
                      ext_temp, die_temp, external_temperature_peak, 16'h0};
            commit_r <= 1'b1;
            log_present <= 1'b1;
            state_r <= ST_DONE;
          end
        end
        ST_DONE: begin
          // Triggers are dropped until the log is cleared
          if (log_clear) begin
            log_present <= 1'b0;
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Byte selection for the block read
  always @* begin
    page_rel = rd_addr - `PAGE_BASE;
    page_quot = page_rel / `PAGE_BYTES;
    page_off = 8'h0;
    page_idx = 3'h0;
    slot = 3'h0;
    sel_page = 160'h0;
    rd_data = 8'h0;
    if (rd_addr == `B_SRC) begin
      rd_data = src_r;
    end else if (rd_addr < `B_VOUTPK) begin
      // Time snapshot, low byte first
      rd_data = time_snap_r[((rd_addr - `B_TIME0) * 8) +: 8];
    end else if (rd_addr < `PAGE_BASE) begin
      // Header fields, high byte first; gaps fall to zero
      case (rd_addr)
        `B_VOUTPK: rd_data = hdr_r[127:120];
        `B_VOUTPK + 8'h1: rd_data = hdr_r[119:112];
        `B_IOUTPK: rd_data = hdr_r[111:104];
        `B_IOUTPK + 8'h1: rd_data = hdr_r[103:96];
        `B_IINCPK: rd_data = hdr_r[95:88];
        `B_IINCPK + 8'h1: rd_data = hdr_r[87:80];
        `B_VINPK: rd_data = hdr_r[79:72];
        `B_VINPK + 8'h1: rd_data = hdr_r[71:64];
        `B_TEXT: rd_data = hdr_r[63:56];
        `B_TEXT + 8'h1: rd_data = hdr_r[55:48];
        `B_TINT: rd_data = hdr_r[47:40];
        `B_TINT + 8'h1: rd_data = hdr_r[39:32];
        `B_TEXTPK: rd_data = hdr_r[31:24];
        `B_TEXTPK + 8'h1: rd_data = hdr_r[23:16];
        default: rd_data = 8'h00;
      endcase
    end else if (rd_addr < `LOG_LEN) begin
      // Page bytes, counted back from the newest slot
      page_idx = page_quot[2:0];
      page_off = page_rel % `PAGE_BYTES;
      // Newest page sits just behind the write head
      slot = (head_r >= page_idx + 3'h1) ? head_r - page_idx - 3'h1
                                         : head_r + `PAGE_COUNT - page_idx - 3'h1;
      sel_page = pages[slot];
      rd_data = sel_page[(8'd159 - page_off * 8) -: 8];
    end
  end

  // Block length answer
  always @* begin
    block_length = log_present ? `LOG_LEN : 8'h00;
  end
endmodule // fault_log_record_formatter
`default_nettype wire

// File: verification/log_props.sv
// Port checks for the fault log record formatter
`timescale 1ns/100ps
`default_nettype none
module log_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic logging_enable,
  input wire logic fault_event,
  input wire logic forced_log_store,
  input wire logic log_clear,
  input wire logic step_done,
  input wire logic [4:0] adc_step,
  input wire logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic [7:0] block_length,
  input wire logic log_present,
  input wire logic commit_pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic armed_r;
  // Trigger taken and not yet answered by a commit
  always @(posedge clk) begin
    if (!rst_n) begin
      armed_r <= 1'b0;
    end else if (commit_pulse) begin
      armed_r <= 1'b0;
    end else if ((fault_event || forced_log_store) && logging_enable && !log_present) begin
      armed_r <= 1'b1;
    end
  end
  // Trigger taken, then end of the mux pass
  sequence trig_s;
    (fault_event || forced_log_store) && logging_enable && !log_present;
  endsequence
  sequence pass_end_s;
    step_done && adc_step == 5'h19;
  endsequence
  len_match_a: assert property (block_length == (log_present ? 8'h93 : 8'h00))
    else $error("block length wrong");
  pass_commit_a: assert property (trig_s ##1 pass_end_s |=> commit_pulse)
    else $error("no commit after pass");
  commit_cause_a: assert property (commit_pulse |-> $past(step_done && adc_step == 5'h19))
    else $error("commit off pass end");
  commit_once_a: assert property (commit_pulse |=> !commit_pulse)
    else $error("commit pulse shape");
  commit_log_a: assert property (commit_pulse |-> log_present)
    else $error("commit without log");
  pass_armed_a: assert property (armed_r ##0 pass_end_s |=> commit_pulse)
    else $error("armed pass end not committed");
  commit_armed_a: assert property (commit_pulse |-> $past(armed_r))
    else $error("commit without trigger");
  log_rise_a: assert property ($rose(log_present) |-> commit_pulse)
    else $error("log without commit");
  log_hold_a: assert property (log_present && !log_clear |=> log_present)
    else $error("log lost");
  log_clear_a: assert property (log_present && log_clear |=> !log_present)
    else $error("clear ignored");
  reserved_zero_a: assert property (rd_addr inside {8'h13, 8'h14, 8'h19, 8'h1A, 8'h1D,
    8'h1E, 8'h28} |-> rd_data == 8'h00)
    else $error("reserved byte set");
endmodule // log_props
bind fault_log_record_formatter log_props i_log_props (
  .clk(clk),
  .rst_n(rst_n),
  .logging_enable(logging_enable),
  .fault_event(fault_event),
  .forced_log_store(forced_log_store),
  .log_clear(log_clear),
  .step_done(step_done),
  .adc_step(adc_step),
  .rd_addr(rd_addr),
  .rd_data(rd_data),
  .block_length(block_length),
  .log_present(log_present),
  .commit_pulse(commit_pulse)
);
`default_nettype wire

// File: verification/adc_seq_model.sv
// Mux sequencer model: a step completes every second cycle
`timescale 1ns/100ps
`default_nettype none
module adc_seq_model (
  input wire logic clk,
  input wire logic rst_n,
  output logic step_done,
  output logic [4:0] adc_step,
  output logic [7:0] pass_no
);
  // Steps 0 to 25, passes counted
  always @(negedge clk) begin
    if (!rst_n) begin
      step_done <= 1'b0;
      adc_step <= 5'h00;
      pass_no <= 8'h00;
    end else if (step_done) begin
      step_done <= 1'b0;
      adc_step <= (adc_step == 5'h19) ? 5'h00 : adc_step + 5'h01;
      pass_no <= pass_no + {7'h00, adc_step == 5'h19};
    end else begin
      step_done <= 1'b1;
    end
  end
endmodule // adc_seq_model
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench for the fault log record formatter
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk = 0, rst_n = 0, en = 0, flt = 0, frc = 0, clr = 0;
  logic [7:0] code = 8'h03, addr = 8'h00, pv;
  logic [15:0] b = 16'h1234;
  wire sd, cp, lp;
  wire [4:0] st;
  wire [7:0] pn, rdd, bl;
  int fails = 0, total_checks = 0;
  localparam int TICKS = 4;
  int cyc = 0;
  logic [15:0] ts;
  // Clock and parts
  always #2 clk = ~clk;
  // Clock edges since reset release, for the time stamp
  always @(posedge clk) if (rst_n) cyc <= cyc + 1;
  adc_seq_model i_adc_seq_model (.clk(clk), .rst_n(rst_n), .step_done(sd), .adc_step(st),
    .pass_no(pn));
  fault_log_record_formatter #(.TICK_CYCLES(TICKS)) i_fault_log_record_formatter (.clk(clk),
    .rst_n(rst_n), .logging_enable(en), .fault_event(flt), .fault_code(code),
    .forced_log_store(frc), .log_clear(clr), .step_done(sd), .adc_step(st), .vout_peak(b),
    .iout_peak(b), .channel_input_current_peak(b + 16'h0102), .input_voltage_peak(b + 16'h0203),
    .external_temperature_peak(b + 16'h0304), .ext_temp(b + 16'h0405), .die_temp(b + 16'h0506),
    .vout({8'hA0, pn}), .iout(b), .channel_input_current(b), .vin(b), .iin(b),
    .status_vout(b[7:0]), .status_word(b), .status_mfr(b[7:0]), .rd_addr(addr),
    .rd_data(rdd), .block_length(bl), .log_present(lp), .commit_pulse(cp));
  // Shared helpers
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk) addr = a;
    #1 chk("rd_data", rdd, e);
  endtask
  task automatic rd16(input logic [7:0] a, input logic [15:0] v);
    rd(a, v[15:8]);
    rd(a + 8'h01, v[7:0]);
  endtask
  task automatic pulse(input logic f, input logic want, input int w);
    @(negedge clk) if (f) flt = 1; else frc = 1;
    pv = pn;
    ts = 16'(cyc / TICKS);
    @(negedge clk) flt = 0;
    frc = 0;
    for (int i = 0; i < w && cp !== 1'b1; i++) @(posedge clk) #1;
    chk("commit_pulse", {7'h00, cp}, {7'h00, want});
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Scenarios
  task automatic t_off;
    chk("block_length", bl, 8'h00);
    pulse(1, 0, 60);
    chk("log_present", {7'h00, lp}, 8'h00);
    $display("t_off done");
  endtask
  task automatic t_fault;
    logic [7:0] rsv [7] = '{8'h09, 8'h0A, 8'h14, 8'h19, 8'h1A, 8'h1D, 8'h92};
    @(negedge clk) en = 1;
    for (int i = 0; i < 60 && st !== 5'h0F; i++) @(negedge clk);
    chk("adc_step", {3'h0, st}, 8'h0F);
    pulse(1, 1, 60);
    chk("commit_pulse", {7'h00, cp}, 8'h01);
    rd(8'h00, 8'h03);
    rd(8'h01, ts[7:0]);
    rd(8'h02, ts[15:8]);
    rd(8'h06, 8'h00);
    rd16(8'h0D, b + 16'h0102);
    rd16(8'h0F, b + 16'h0203);
    rd16(8'h11, b + 16'h0405);
    rd16(8'h15, b + 16'h0506);
    rd16(8'h17, b + 16'h0304);
    rd16(8'h1B, {8'hA0, pv});
    rd16(8'h1F, b);
    rd(8'h2F, 8'hA0);
    rd(8'h30, pv - 8'h01);
    rd(8'h27, b[7:0]);
    foreach (rsv[i]) rd(rsv[i], 8'h00);
    rd(8'h13, 8'h00);
    rd(8'h1E, 8'h00);
    rd(8'h28, 8'h00);
    chk("block_length", bl, 8'h93);
    $display("t_fault done");
  endtask
  task automatic t_held;
    pulse(0, 0, 60);
    rd(8'h00, 8'h03);
    @(negedge clk) clr = 1;
    @(negedge clk) clr = 0;
    chk("block_length", bl, 8'h00);
    pulse(0, 1, 60);
    rd(8'h00, 8'hFF);
    $display("t_held done");
  endtask
  // Main sequence
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1;
    t_off();
    t_fault();
    t_held();
    close_out();
  end
endmodule // testbench
`default_nettype wire
